// >>> inc/wdc_pkg.sv
// Purpose: Shared constants and types for the watchdog down-counter block.
// Assumes: AXI4-Lite slave with 32-bit data and one aligned word per register.
// Notes:   Control fields travel as one packed struct.
package wdc_pkg;

    localparam logic [3:0]  ADDR_RELOAD   = 4'h0;
    localparam logic [3:0]  ADDR_COUNT    = 4'h4;
    localparam logic [3:0]  ADDR_CONTROL  = 4'h8;

    localparam logic [31:0] RESET_RELOAD  = 32'h0000_0000;
    localparam logic [31:0] RESET_COUNT   = 32'h0000_FFFF;
    localparam logic [15:0] RESET_CONTROL = 16'h805C;

    localparam int          BIT_FREEZE    = 15;
    localparam int          BIT_PENDING   = 8;
    localparam int          BIT_IRQ_EN    = 7;
    localparam int          BIT_RESET_EN  = 6;
    localparam int          BIT_WRITE_EN  = 5;
    localparam int          BIT_COUNT_EN  = 4;
    localparam int          BIT_CLK_SEL   = 3;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    localparam int          CLK_HZ        = 10_000_000;
    localparam int          OSC_HZ        = 1_000_000;
    localparam int          TIMEOUT_MS    = 2_000;

    typedef struct packed {
        logic       debug_freeze;
        logic       underflow_pending;
        logic       underflow_irq_enable;
        logic       underflow_reset_enable;
        logic       reload_write_enable;
        logic       counter_enable;
        logic       source_clock_select;
        logic [2:0] count_divider_code;
    } wdc_ctrl_s;

endpackage

// >>> design/wdc_watchdog.sv
// Purpose: Watchdog with a 32-bit down-counter, prescaler and AXI4-Lite registers.
// Assumes: ring_oscillator is a slow level sampled on clk; debug_halt is synchronous.
// Notes:   All outputs are registered; one write and one read at a time on the bus.
//
// Register access over AXI4-Lite was left to the implementer.

// What this block does
// - A 32-bit counter counts down once per prescaled count clock while enabled.
// - Software picks reset or periodic interrupt as the underflow action.
// - Reload, count and control registers sit at offsets 0x0, 0x4 and 0x8.
// - Reset values give an initial timeout of about two seconds.
// - The current count reads 0x0000FFFF after reset.
// - The control register reads 0x0000805C after reset.
// - A reload write loads the counter only while the write-enable bit is 1.
// - After a load counting continues from the new value; count reads live.
// - Reaching zero triggers the enabled interrupt or reset action.
// - Control bit 15 set halts the counter while the processor is in debug.
// - Control bit 8 is set on underflow and reads 0 when none is pending.
// - Interrupt only while bit 7 is 1; system reset only while bit 6 is 1.
// - Control bit 4 enables the counter; at 0 the counter holds.
// - Control bit 3 selects bus clock (0) or 1 MHz ring oscillator (1).
// - Bits 2..0 divide by 1, 4, 8, 16, 32, 64, 128 or 256.
// - An output signal tells surrounding logic that the counter underflowed.
// - In interrupt mode the counter reloads from the load value after underflow.
// - A new load value appears in the count within five count clocks.
// - Interrupt and bus count lag the counter by at most two bus clocks.
module wdc_watchdog
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ring_oscillator,
    input  wire logic        debug_halt,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             watchdog_irq,
    output logic             watchdog_reset,
    output logic             underflow_pulse
);

    wdc_pkg::wdc_ctrl_s ctrl;
    logic [31:0]        reload_value;
    logic [31:0]        down_counter_value;
    logic [7:0]         divider_count;
    logic               osc_meta;
    logic               osc_sync;
    logic               osc_prev;
    logic [3:0]         aw_addr;
    logic               aw_held;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               w_held;

    logic               write_fire;
    logic               write_hit;
    logic               source_tick;
    logic               running;
    logic [7:0]         divide_last;
    logic               count_tick;
    logic               load_now;
    logic               underflow_event;
    logic [15:0]        ctrl_bits;
    logic [31:0]        merged_wdata;

    assign ctrl_bits = {ctrl.debug_freeze, 6'h00, ctrl.underflow_pending,
                        ctrl.underflow_irq_enable, ctrl.underflow_reset_enable,
                        ctrl.reload_write_enable, ctrl.counter_enable,
                        ctrl.source_clock_select, ctrl.count_divider_code};

    // Both halves of a write are held until the response is out
    assign write_fire = aw_held && w_held && !s_axi_bvalid;
    assign write_hit  = aw_addr == wdc_pkg::ADDR_RELOAD || aw_addr == wdc_pkg::ADDR_CONTROL;

    always_comb
    begin
        merged_wdata = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            merged_wdata[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8] : 8'h00;
        end
    end

    // Write address and data taken in either order
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            aw_held       <= 1'b0;
            aw_addr       <= 4'h0;
            s_axi_awready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (write_fire)
            begin
                aw_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (write_fire)
            begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= wdc_pkg::RESP_OKAY;
        end
        else if (write_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= write_hit ? wdc_pkg::RESP_OKAY : wdc_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read: arready for one cycle, data the cycle after
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= wdc_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= wdc_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    wdc_pkg::ADDR_RELOAD:  s_axi_rdata <= 32'h0000_0000;
                    wdc_pkg::ADDR_COUNT:   s_axi_rdata <= down_counter_value;
                    wdc_pkg::ADDR_CONTROL: s_axi_rdata <= {16'h0000, ctrl_bits};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= wdc_pkg::RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Control register; the set of the pending flag wins over a clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl <= wdc_pkg::wdc_ctrl_s'({wdc_pkg::RESET_CONTROL[15], wdc_pkg::RESET_CONTROL[8:0]});
        end
        else
        begin
            if (write_fire && aw_addr == wdc_pkg::ADDR_CONTROL)
            begin
                if (w_strb[1])
                begin
                    ctrl.debug_freeze <= w_data[wdc_pkg::BIT_FREEZE];
                    if (w_data[wdc_pkg::BIT_PENDING])
                    begin
                        ctrl.underflow_pending <= 1'b0;
                    end
                end
                if (w_strb[0])
                begin
                    ctrl.underflow_irq_enable   <= w_data[wdc_pkg::BIT_IRQ_EN];
                    ctrl.underflow_reset_enable <= w_data[wdc_pkg::BIT_RESET_EN];
                    ctrl.reload_write_enable    <= w_data[wdc_pkg::BIT_WRITE_EN];
                    ctrl.counter_enable         <= w_data[wdc_pkg::BIT_COUNT_EN];
                    ctrl.source_clock_select    <= w_data[wdc_pkg::BIT_CLK_SEL];
                    ctrl.count_divider_code     <= w_data[2:0];
                end
            end
            if (underflow_event)
            begin
                ctrl.underflow_pending <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reload_value <= wdc_pkg::RESET_RELOAD;
        end
        else if (write_fire && aw_addr == wdc_pkg::ADDR_RELOAD)
        begin
            reload_value <= merged_wdata;
        end
    end

    // Oscillator is far slower than clk, so a two-flop sync plus edge detect is enough
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end
        else
        begin
            osc_meta <= ring_oscillator;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    assign source_tick = ctrl.source_clock_select ? (osc_sync && !osc_prev) : 1'b1;
    assign running     = ctrl.counter_enable && !(ctrl.debug_freeze && debug_halt);
    assign divide_last = ctrl.count_divider_code == 3'h0 ? 8'h00
                       : 8'((9'h001 << ({1'b0, ctrl.count_divider_code} + 4'h1)) - 9'h001);
    assign count_tick  = running && source_tick && divider_count >= divide_last;
    assign load_now    = write_fire && aw_addr == wdc_pkg::ADDR_RELOAD && ctrl.reload_write_enable;
    assign underflow_event = count_tick && !load_now && down_counter_value == 32'h0000_0001;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            divider_count <= 8'h00;
        end
        else if (load_now || count_tick)
        begin
            divider_count <= 8'h00;
        end
        else if (running && source_tick)
        begin
            divider_count <= divider_count + 8'h01;
        end
    end

    // Counter stops at zero unless interrupt mode reloads it
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            down_counter_value <= wdc_pkg::RESET_COUNT;
        end
        else if (load_now)
        begin
            down_counter_value <= merged_wdata;
        end
        else if (count_tick)
        begin
            if (down_counter_value != 32'h0000_0000)
            begin
                down_counter_value <= down_counter_value - 32'h0000_0001;
            end
            else if (ctrl.underflow_irq_enable)
            begin
                down_counter_value <= reload_value;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            watchdog_irq    <= 1'b0;
            watchdog_reset  <= 1'b0;
            underflow_pulse <= 1'b0;
        end
        else
        begin
            watchdog_irq    <= ctrl.underflow_irq_enable && (ctrl.underflow_pending || underflow_event);
            watchdog_reset  <= ctrl.underflow_reset_enable && underflow_event;
            underflow_pulse <= underflow_event;
        end
    end

endmodule

// >>> sim/wdc_watchdog_properties.sv
// Purpose: Concurrent checks on the watchdog bus and event outputs.
// Assumes: Bound to wdc_watchdog; a single clock domain.
// Notes:   Control bits are not visible here, so events are tied to each other.
module wdc_watchdog_properties
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        watchdog_irq,
    input wire logic        watchdog_reset,
    input wire logic        underflow_pulse
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    write_resp_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    read_resp_a: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
        else $error("read response missing");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    unmapped_read_a: assert property (rd_taken ##0 !(s_axi_araddr inside {4'h0, 4'h4, 4'h8})
        |-> ##[1:2] s_axi_rvalid && s_axi_rresp == wdc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("address ready held too long");
    reset_pulse_a: assert property (watchdog_reset |-> underflow_pulse ##1 !watchdog_reset)
        else $error("system reset without single underflow");
    irq_cause_a: assert property ($rose(watchdog_irq) |-> underflow_pulse)
        else $error("interrupt rose without underflow");
    pulse_gap_a: assert property (underflow_pulse |=> !underflow_pulse)
        else $error("underflow pulse too long");
endmodule
bind wdc_watchdog wdc_watchdog_properties i_props (.*);

// >>> sim/watchdog_down_counter_tb_top.sv
// Purpose: Self-checking bench for the watchdog down-counter.
// Assumes: Oscillator runs only in the last scenario; earlier ones count on the bus clock.
// Notes:   Every wait is bounded; a hang ends in the closing report.
module watchdog_down_counter_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [1:0] OK = wdc_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = wdc_pkg::RESP_SLVERR;
    logic        clk = 1'h0, rstn = 1'h0, ring_oscillator = 1'h0, debug_halt = 1'h0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        watchdog_irq, watchdog_reset, underflow_pulse;
    int          failures = 0, cmp_count = 0, n;
    logic        osc_run = 1'h0;
    int          osc_div = 0;

    always #50 clk = ~clk;

    // Toggles every five bus clocks: a steady ten-clock oscillator period
    always @(posedge clk)
    begin
        osc_div <= (osc_div == 4) ? 0 : osc_div + 1;
        if (osc_run && osc_div == 4)
            ring_oscillator <= !ring_oscillator;
    end

    wdc_watchdog i_dut (.*);

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic bound(input int lim);
        if (n >= lim)
        begin
            failures++;
            results();
        end
    endtask

    // Response ready stands up while waiting, so the answer is taken at the edge it is first seen
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid)
                break;
        end
        bound(50);
        s_axi_bready <= 1'h0;
        chk("bresp", 32'(s_axi_bresp), 32'(er));
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid)
                break;
        end
        bound(50);
        s_axi_rready <= 1'h0;
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", 32'(s_axi_rresp), 32'(er));
    endtask

    // Leaves n at the number of edges since the previous return
    task automatic pulse(input int lim);
        for (n = 1; n < lim; n++)
        begin
            @(posedge clk);
            if (underflow_pulse === 1'h1)
                break;
        end
        bound(lim);
    endtask

    task automatic t_regs();
        rd(4'h8, 32'h0000_805C, OK);
        rd(4'h4, 32'h0000_FFFF, OK);
        rd(4'h0, 32'h0000_0000, OK);
        rd(4'hC, 32'h0000_0000, ERR);
        wr(4'h4, 32'h0000_1234, ERR);
        rd(4'h4, 32'h0000_FFFF, OK);
    endtask

    task automatic t_load();
        wr(4'h8, 32'h0000_0020, OK);
        wr(4'h0, 32'h0000_0100, OK);
        rd(4'h4, 32'h0000_0100, OK);
        wr(4'h8, 32'h0000_0000, OK);
        wr(4'h0, 32'h0000_0077, OK);
        rd(4'h4, 32'h0000_0100, OK);
        debug_halt <= 1'h1;
        wr(4'h8, 32'h0000_8010, OK);
        repeat (20) @(posedge clk);
        rd(4'h4, 32'h0000_0100, OK);
    endtask

    // Debug stays high from here on: with the freeze bit clear the counter must run
    task automatic t_irq();
        wr(4'h8, 32'h0000_00B0, OK);
        wr(4'h0, 32'h0000_0014, OK);
        pulse(100);
        chk("irq", 32'(watchdog_irq), 32'h1);
        chk("sysreset", 32'(watchdog_reset), 32'h0);
        wr(4'h8, 32'h0000_00A0, OK);
        rd(4'h8, 32'h0000_01A0, OK);
        chk("irq", 32'(watchdog_irq), 32'h1);
        wr(4'h8, 32'h0000_01A0, OK);
        rd(4'h8, 32'h0000_00A0, OK);
        chk("irq", 32'(watchdog_irq), 32'h0);
    endtask

    task automatic t_rst();
        wr(4'h8, 32'h0000_0070, OK);
        wr(4'h0, 32'h0000_0003, OK);
        pulse(30);
        chk("sysreset", 32'(watchdog_reset), 32'h1);
        chk("irq", 32'(watchdog_irq), 32'h0);
        rd(4'h4, 32'h0000_0000, OK);
        rd(4'h8, 32'h0000_0170, OK);
    endtask

    // Third pulse only: the first may predate the reload
    task automatic t_div();
        int d;
        for (int c = 0; c < 8; c++)
        begin
            d = (c == 0) ? 1 : 2 << c;
            wr(4'h8, 32'h0000_01B0 | c, OK);
            wr(4'h0, 32'h0000_0002, OK);
            pulse(800);
            pulse(800);
            pulse(800);
            chk("period", n, 3 * d);
        end
    endtask

    // Source tick every ten bus clocks at divide by 1: three ticks per period
    task automatic t_osc();
        osc_run <= 1'h1;
        wr(4'h8, 32'h0000_01B8, OK);
        wr(4'h0, 32'h0000_0002, OK);
        pulse(800);
        pulse(800);
        pulse(800);
        chk("osc period", n, 32'h0000_001E);
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        rstn <= 1'h1;
        t_regs();
        t_load();
        t_irq();
        t_rst();
        t_div();
        t_osc();
        results();
    end
endmodule
